/* File: logic/sep_pkg.sv */
// sep_pkg: constants for the serial eeprom slave
// assumes a 200 MHz system clock; used by logic/sep_eeprom.sv
`default_nettype none
package sep_pkg;
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned T_WR_US    = 5000;
  localparam int unsigned WR_CYC     = T_WR_US * CLK_MHZ;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned MEM_WORDS  = 2048;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned ROW_W      = 4;
  localparam int unsigned ROW_BYTES  = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W     = 12;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [3:0]  BIT_D0     = 4'h7;
  // device type code: value is arbitrary
  localparam logic [3:0]  DEV_TYPE   = 4'h5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_WORD = 3'b011,
    ST_WR   = 3'b010,
    ST_PROG = 3'b110,
    ST_RD   = 3'b101,
    ST_WAIT = 3'b100
  } sep_state_e;
endpackage
`default_nettype wire

/* File: logic/sep_fifo.sv */
// sep_fifo: small valid/ready fifo
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned D = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_q != (PW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: logic/sep_eeprom.sv */
// sep_eeprom: two-wire serial eeprom slave, 2048 x 8 array
// assumes scl, sda and write-protect come from pins outside clk_sys_i;
// sda is open drain, resolved outside from sda_oe_o.
// Function
// - master ack low: send next byte
// - no ack: stop sending, await stop
// - sequential read after current or random
// - write-protect ignored before first data bit zero
// - write-protect high later cancels pending write
// - write-protect during write cycle aborts programming
// - cancelled write returns to standby at once
// - software reset by clocks and starts
// - busy device ignores commands, no ack
// - ack polling shows write cycle end
// - start then stop cancels command input
// - cancelled read leaves address undefined
// - programming starts only upon stop
// - address: past read, at last write
// - write-protect high from first data bit zero refuses the write
// - page select bits form top address bits
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom #(
  parameter int unsigned WR_CYC = sep_pkg::WR_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      busy_o
);
  import sep_pkg::*;

  // ==========================================================
  // pin synchronisers and bus events
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic [1:0] wp_sy_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic       rise;
  logic       fall;
  logic       start_ev;
  logic       stop_ev;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      wp_sy_q  <= 2'h0;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      wp_sy_q  <= {wp_sy_q[0], wp_i};
      scl_p_q  <= scl_sy_q[1];
      sda_p_q  <= sda_sy_q[1];
    end
  end

  assign scl_s    = scl_sy_q[1];
  assign sda_s    = sda_sy_q[1];
  assign wp_s     = wp_sy_q[1];
  assign rise     = scl_s & ~scl_p_q;
  assign fall     = ~scl_s & scl_p_q;
  // any start outside a write cycle resyncs the engine, so nine starts or dummy clocks
  // followed by a start always land in address input
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ==========================================================
  // command state
  sep_state_e          st_q;
  logic [3:0]          bit_q;
  logic [7:0]          sh_q;
  logic [7:0]          rd_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [PAGE_W-1:0]   page_q;
  logic                ack_q;
  logic                wfirst_q;
  logic                armed_q;
  logic                cancel_q;
  logic [19:0]         tmr_q;
  logic [7:0]          pg_dat_q [ROW_BYTES];
  logic [ROW_BYTES-1:0] pg_vld_q;
  logic [7:0]          mem_q [MEM_WORDS];
  logic                ack_clk;
  logic                rd_load;
  logic                tmr_done;
  logic                dev_hit;
  logic [ROW_W-1:0]    widx;
  logic                f_in_rdy;
  logic                f_out_vld;
  logic [FIFO_W-1:0]   f_out;
  logic                f_push;
  logic                f_pop;

  assign ack_clk  = rise & (bit_q == BIT_ACK);
  assign dev_hit  = (sh_q[7:4] == DEV_TYPE);
  assign tmr_done = (st_q == ST_PROG) & (tmr_q == '0);
  // next read byte is fetched on the ack clock of address or data
  assign rd_load  = ack_clk & (((st_q == ST_DEV) & ack_q & sh_q[0]) |
                               ((st_q == ST_RD) & ~sda_s));
  assign widx     = wfirst_q ? addr_q[ROW_W-1:0]
                             : addr_q[ROW_W-1:0] + 1'b1;
  assign f_push   = fall & (bit_q == BIT_ACK) & (st_q == ST_WR);
  // page latch stops draining while the array is programmed
  assign f_pop    = f_out_vld & (st_q != ST_PROG);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st_q  <= ST_IDLE;
      bit_q <= '0;
      sh_q  <= '0;
    end else if (st_q == ST_PROG) begin
      if (wp_s || tmr_done) begin
        st_q <= ST_IDLE;
      end
    end else if (start_ev) begin
      st_q  <= ST_DEV;
      bit_q <= '0;
    end else if (stop_ev) begin
      if (st_q == ST_WR && pg_vld_q != '0 && !cancel_q && !wp_s) begin
        st_q <= ST_PROG;
      end else begin
        st_q <= ST_IDLE;
      end
    end else if (rise && st_q != ST_IDLE && st_q != ST_WAIT) begin
      if (bit_q != BIT_ACK) begin
        sh_q  <= {sh_q[6:0], sda_s};
        bit_q <= bit_q + 1'b1;
      end else begin
        bit_q <= '0;
        unique case (st_q)
          ST_DEV:  st_q <= !ack_q ? ST_WAIT : (sh_q[0] ? ST_RD : ST_WORD);
          ST_WORD: st_q <= ST_WR;
          ST_WR:   st_q <= ack_q ? ST_WR : ST_WAIT;
          ST_RD:   st_q <= sda_s ? ST_WAIT : ST_RD;
          default: st_q <= ST_WAIT;
        endcase
      end
    end
  end

  // ack decision on the falling edge that opens the ninth clock
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else if (start_ev || stop_ev || st_q == ST_PROG) begin
      ack_q <= 1'b0;
    end else if (fall) begin
      ack_q <= (bit_q == BIT_ACK) &&
               (((st_q == ST_DEV) && dev_hit) || (st_q == ST_WORD) ||
                ((st_q == ST_WR) && f_in_rdy));
    end
  end

  // address counter and page select
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_q   <= '0;
      page_q   <= '0;
      wfirst_q <= 1'b0;
    end else if (fall && bit_q == BIT_ACK && st_q == ST_DEV && dev_hit) begin
      page_q <= sh_q[3:1];
    end else if (fall && bit_q == BIT_ACK && st_q == ST_WORD) begin
      addr_q   <= {page_q, sh_q};
      wfirst_q <= 1'b1;
    end else if (f_push && f_in_rdy) begin
      addr_q[ROW_W-1:0] <= widx;
      wfirst_q          <= 1'b0;
    end else if (rd_load) begin
      // a cancelled read keeps whatever count it reached
      addr_q <= addr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rd_load) begin
      rd_q <= mem_q[addr_q];
    end
  end

  // write-protect is only looked at once bit zero of data was sampled
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      armed_q  <= 1'b0;
      cancel_q <= 1'b0;
    end else if (start_ev) begin
      armed_q  <= 1'b0;
      cancel_q <= 1'b0;
    end else begin
      if (rise && st_q == ST_WR && bit_q == BIT_D0) begin
        armed_q <= 1'b1;
      end
      if ((armed_q || (rise && st_q == ST_WR && bit_q == BIT_D0)) && wp_s)
      begin
        cancel_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // received bytes pass the fifo into the page latch
  sep_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) i_sep_fifo (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_rdy),
    .in_data_i   ({widx, sh_q}),
    .out_valid_o (f_out_vld),
    .out_ready_i (f_pop),
    .out_data_o  (f_out)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pg_vld_q <= '0;
    end else if (start_ev && st_q != ST_PROG) begin
      pg_vld_q <= '0;
    end else if (f_pop) begin
      pg_vld_q[f_out[FIFO_W-1:8]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (f_pop) begin
      pg_dat_q[f_out[FIFO_W-1:8]] <= f_out[7:0];
    end
  end

  // ==========================================================
  // write cycle timer and array programming
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || st_q != ST_PROG) begin
      tmr_q <= 20'(WR_CYC - 1);
    end else begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // an aborted cycle simply leaves the old bytes in place
  always_ff @(posedge clk_sys_i) begin
    if (tmr_done && !wp_s) begin
      for (int i = 0; i < ROW_BYTES; i++) begin
        if (pg_vld_q[i]) begin
          mem_q[{addr_q[ADDR_W-1:ROW_W], ROW_W'(i)}] <= pg_dat_q[i];
        end
      end
    end
  end

  // ==========================================================
  // open-drain output
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sda_oe_o <= 1'b0;
    end else if (start_ev || stop_ev || st_q == ST_PROG ||
                 st_q == ST_WAIT || st_q == ST_IDLE) begin
      sda_oe_o <= 1'b0;
    end else if (fall) begin
      if (bit_q == BIT_ACK) begin
        sda_oe_o <= ((st_q == ST_DEV) && dev_hit) || (st_q == ST_WORD) ||
                    ((st_q == ST_WR) && f_in_rdy);
      end else begin
        sda_oe_o <= (st_q == ST_RD) && !rd_q[~bit_q[2:0]];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sda_o  <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      sda_o  <= 1'b0;
      busy_o <= (st_q == ST_PROG);
    end
  end

  // ==========================================================
  // checks
  chk_busy_no_ack: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (st_q == ST_PROG) [*2] |-> !sda_oe_o)
    else $error("device drives sda while busy");
  chk_wp_abort: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (st_q == ST_PROG && wp_s) |=> st_q == ST_IDLE)
    else $error("write cycle not aborted by write-protect");
  chk_prog_on_stop: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) $rose(st_q == ST_PROG) |-> $past(stop_ev))
    else $error("programming began without stop");
  chk_cancel_no_prog: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (cancel_q && stop_ev) |=> st_q != ST_PROG)
    else $error("cancelled write still programmed");
  chk_nack_stops: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (ack_clk && st_q == ST_RD && sda_s && !start_ev
    && !stop_ev) |=> st_q == ST_WAIT ##1 !sda_oe_o)
    else $error("read went on after no acknowledge");
  chk_ack_continue: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (ack_clk && st_q == ST_RD && !sda_s && !start_ev
    && !stop_ev) |=> (st_q == ST_RD && bit_q == 4'h0))
    else $error("read stopped after acknowledge");
  chk_addr_step: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) rd_load |=> addr_q == $past(addr_q) + 11'h001)
    else $error("read address did not advance");
  chk_start_stop: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (stop_ev && st_q != ST_PROG && st_q != ST_WR)
    |=> st_q == ST_IDLE)
    else $error("start then stop left a command open");
  chk_wp_early: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (st_q == ST_DEV || st_q == ST_WORD) |-> !cancel_q)
    else $error("write-protect seen before first data bit");
  cov_prog: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    tmr_done && !wp_s);
  cov_seq_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    rd_load && st_q == ST_RD);
  cov_wp_abort: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    st_q == ST_PROG && wp_s);
endmodule
`default_nettype wire

/* File: test/sep_master.sv */
// sep_master: two-wire bus master model, drives scl and pulls sda
// assumes sda_i is the resolved wire with a pull-up; 25 clk per bit
`timescale 1ns/1ps
`default_nettype none
module sep_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // ====================
  // power-up: both lines high; scl stands still between frames
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // sda moves mid-low so it never changes while scl is high
  task automatic bit_io(input logic b, output logic s);
    scl_o  = 1'b0;
    hp(6);
    pull_o = ~b;
    hp(7);
    scl_o  = 1'b1;
    hp(12);
    s      = sda_i;
  endtask
  task automatic start();
    logic s;
    bit_io(1'b1, s);
    pull_o = 1'b1;
    hp(12);
  endtask
  task automatic rel();
    pull_o = 1'b0;
    hp(12);
  endtask
  task automatic stop();
    logic s;
    bit_io(1'b0, s);
    rel();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // more low ends the read with a high acknowledge
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// tb: self-checking bench for sep_eeprom driven by a bus master model
// assumes sep_pkg, sep_fifo, sep_eeprom and sep_master compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sep_pkg::*;
  // ====================
  // short write cycle keeps the polling runs brief
  localparam int unsigned WRC = 2000;
  logic clk_sys_i = 1'b0;
  logic resetn_i;
  logic wp;
  logic scl;
  logic pull;
  logic sda_o;
  logic sda_oe;
  logic busy;
  wire  sda_w     = (sda_oe ? sda_o : 1'b1) & ~pull;
  int   err_count = 0;
  int   cmp_count = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  sep_eeprom #(.WR_CYC(WRC)) i_sep_eeprom (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .scl_i     (scl),
    .sda_i     (sda_w),
    .wp_i      (wp),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe),
    .busy_o    (busy)
  );
  sep_master i_sep_master (
    .clk_i  (clk_sys_i),
    .sda_i  (sda_w),
    .scl_o  (scl),
    .pull_o (pull)
  );
  // ====================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic [2:0] pg, input logic rw);
    return {DEV_TYPE, pg, rw};
  endfunction
  task automatic adr(input logic [10:0] a);
    logic k;
    i_sep_master.start();
    i_sep_master.wbyte(dev(a[10:8], 1'b0), k);
    chk(8'(k), 8'h01);
    i_sep_master.wbyte(a[7:0], k);
    chk(8'(k), 8'h01);
  endtask
  // returns the number of tries, the last one acknowledged
  task automatic poll(output int n);
    logic k;
    n = 0;
    k = 1'b0;
    while (!k && n < 40) begin
      i_sep_master.start();
      i_sep_master.wbyte(dev(3'h0, 1'b0), k);
      i_sep_master.stop();
      n++;
    end
    chk(8'(k), 8'h01);
  endtask
  // w holds write-protect high through the address bytes only
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic w);
    logic k;
    int   n;
    wp = w;
    adr(a);
    wp = 1'b0;
    i_sep_master.wbyte(d[15:8], k);
    i_sep_master.wbyte(d[7:0], k);
    chk(8'(k), 8'h01);
    i_sep_master.stop();
    chk(8'(busy), 8'h01);
    poll(n);
    chk(8'(n > 1), 8'h01);
    chk(8'(busy), 8'h00);
  endtask
  task automatic rnd(input logic [10:0] a);
    logic k;
    adr(a);
    i_sep_master.start();
    i_sep_master.wbyte(dev(a[10:8], 1'b1), k);
    chk(8'(k), 8'h01);
  endtask
  task automatic cur();
    logic k;
    i_sep_master.start();
    i_sep_master.wbyte(dev(3'h0, 1'b1), k);
    chk(8'(k), 8'h01);
  endtask
  task automatic rb(input logic more, input logic [7:0] exp);
    logic [7:0] d;
    i_sep_master.rbyte(more, d);
    chk(d, exp);
  endtask
  // ====================
  // scenarios
  task automatic t_seq();
    logic [7:0] d;
    wr(11'h000, 16'h1122, 1'b0);
    wr(11'h7fe, 16'ha1b2, 1'b0);
    cur();
    rb(1'b1, 8'hb2);
    rb(1'b0, 8'h11);
    i_sep_master.stop();
    rnd(11'h7fe);
    rb(1'b1, 8'ha1);
    rb(1'b1, 8'hb2);
    rb(1'b0, 8'h11);
    i_sep_master.rbyte(1'b0, d);
    chk(d, 8'hff);
    i_sep_master.stop();
    cur();
    rb(1'b0, 8'h22);
    i_sep_master.stop();
  endtask
  task automatic t_wp();
    logic k;
    wr(11'h002, 16'h4455, 1'b1);
    adr(11'h002);
    i_sep_master.wbyte(8'h99, k);
    wp = 1'b1;
    i_sep_master.stop();
    chk(8'(busy), 8'h00);
    adr(11'h002);
    i_sep_master.wbyte(8'h98, k);
    i_sep_master.stop();
    chk(8'(busy), 8'h00);
    wp = 1'b0;
    rnd(11'h002);
    rb(1'b1, 8'h44);
    rb(1'b0, 8'h55);
    i_sep_master.stop();
    // abort in mid write cycle: data there is lost, not checked
    adr(11'h004);
    i_sep_master.wbyte(8'h66, k);
    i_sep_master.stop();
    wp = 1'b1;
    i_sep_master.hp(10);
    chk(8'(busy), 8'h00);
    i_sep_master.start();
    i_sep_master.wbyte(dev(3'h0, 1'b0), k);
    chk(8'(k), 8'h01);
    i_sep_master.stop();
    wp = 1'b0;
  endtask
  task automatic t_cancel();
    logic k;
    adr(11'h001);
    i_sep_master.wbyte(8'h99, k);
    i_sep_master.start();
    i_sep_master.rel();
    chk(8'(busy), 8'h00);
    rnd(11'h001);
    rb(1'b0, 8'h22);
    i_sep_master.stop();
  endtask
  task automatic t_swr();
    logic k;
    for (int v = 0; v < 3; v++) begin
      cur();
      case (v)
        0: begin
          repeat (14) i_sep_master.bit_io(1'b1, k);
          repeat (2) i_sep_master.start();
        end
        1: begin
          i_sep_master.start();
          repeat (9) i_sep_master.bit_io(1'b1, k);
          i_sep_master.start();
        end
        default: repeat (9) i_sep_master.start();
      endcase
      rnd(11'h001);
      rb(1'b0, 8'h22);
      i_sep_master.stop();
    end
  endtask
  // ====================
  // verdict
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    wp       = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk(8'(busy), 8'h00);
    chk(8'(sda_o), 8'h00);
    chk(8'(sda_oe), 8'h00);
    repeat (9) i_sep_master.start();
    i_sep_master.rel();
    t_seq();
    t_wp();
    t_cancel();
    t_swr();
    wrap_up();
  end
  // the whole run needs well under half of this span
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    err_count++;
    $display("wrong value at %0t ns: run did not finish", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
